// file: hdl/insn_decoder.sv
// instruction decoder and sequencer with an apb register window
//
// Operation
// - each instruction is one 14-bit word: opcode in high bits, operands below
// - byte ops: destination bit 0 sends result to accumulator, 1 to file
// - file operand is seven bits, addressing 0 to 7F hex
// - bit ops: three-bit field picks the bit of the 8-bit file register
// - literals are 8 bits; call/jump carry 11-bit target, two cycles
// - one cycle each; two when a test holds or the counter changes
// - one instruction cycle is four consecutive clock periods
// - byte alu opcodes; add/sub touch carry, digit carry, zero; logic, move, inc, dec, clear zero only
// - rotates through carry alter only carry; nibble swap alters nothing
// - decrement/increment-and-skip skip on zero result, no flags touched
// - bit ops class 01 clear, set, test clear, test set; no flags
// - bit tests take one cycle, two when the skip is taken
// - return-with-literal loads accumulator and returns; returns take two
// - standby and watchdog clear both update timeout and powerdown flags
// - literal add/sub update carry, digit carry, zero; 00xx loads literal
// - literal or/and/xor combine with accumulator, zero flag only
// - don't-care opcode bits are ignored, either value decodes the same
// - standby clears watchdog and powerdown, sets timeout, stops oscillator
`default_nettype none
module insn_decoder
   import insn_decoder_pkg::*;
#(
   parameter int PC_W = 13
) (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output var  logic [31:0]           prdata,
   output logic                       pready,
   output var  logic                  pslverr,
   // program memory
   input  wire logic [INSN_W-1:0]     instr_word,
   output logic                       fetch_strobe,
   output var  logic [PC_W-1:0]       program_counter,
   // stack and paging
   input  wire logic [PC_W-1:0]       return_addr,
   input  wire logic [PC_W-TARGET_W-1:0] page_bits,
   output logic                       stack_push,
   output logic                       stack_pop,
   // datapath feedback
   input  wire logic                  alu_zero,
   input  wire logic                  tested_bit,
   // decoded controls
   output var  logic                  exec_valid,
   output var  alu_op_t               alu_op,
   output var  logic                  dest_is_reg,
   output var  logic                  src_literal,
   output var  logic [FILE_W-1:0]     file_addr,
   output var  logic [BITSEL_W-1:0]   bit_sel,
   output var  logic [LIT_W-1:0]      literal,
   output var  logic                  upd_carry,
   output var  logic                  upd_digit_carry,
   output var  logic                  upd_zero,
   output var  logic [1:0]            q_phase,
   // power and watchdog
   output logic                       watchdog_clear,
   output var  logic                  timeout_flag,
   output var  logic                  powerdown_flag,
   output var  logic                  osc_stop
);
   // refused at elaboration: a jump target needs room for page bits
   if (PC_W < TARGET_W + 1 || PC_W > 16) begin
      $error("PC_W must lie between 12 and 16");
   end

   // =========================================================
   // decode
   function automatic decode_t decode(input logic [INSN_W-1:0] w);
      decode_t d;
      d.op       = ALU_NONE;
      d.flow     = FLOW_SEQ;
      d.dest_reg = 1'b0;
      d.src_lit  = 1'b0;
      d.upd_c    = 1'b0;
      d.upd_dc   = 1'b0;
      d.upd_z    = 1'b0;
      d.standby  = 1'b0;
      d.wd_clear = 1'b0;
      unique case (w[13:12])
         CLASS_BYTE: begin
            d.dest_reg = w[7];
            unique case (w[11:8])
               SUB_ADD:   begin d.op = ALU_ADD; d.upd_c = 1'b1;
                             d.upd_dc = 1'b1; d.upd_z = 1'b1; end
               SUB_SUB:   begin d.op = ALU_SUB; d.upd_c = 1'b1;
                             d.upd_dc = 1'b1; d.upd_z = 1'b1; end
               SUB_AND:   begin d.op = ALU_AND;   d.upd_z = 1'b1; end
               SUB_OR:    begin d.op = ALU_OR;    d.upd_z = 1'b1; end
               SUB_XOR:   begin d.op = ALU_XOR;   d.upd_z = 1'b1; end
               SUB_COMPL: begin d.op = ALU_COMPL; d.upd_z = 1'b1; end
               SUB_MOVE:  begin d.op = ALU_MOVE;  d.upd_z = 1'b1; end
               SUB_DEC:   begin d.op = ALU_DEC;   d.upd_z = 1'b1; end
               SUB_INC:   begin d.op = ALU_INC;   d.upd_z = 1'b1; end
               SUB_CLEAR: begin d.op = ALU_CLEAR; d.upd_z = 1'b1; end
               SUB_RLC:   begin d.op = ALU_RLC;   d.upd_c = 1'b1; end
               SUB_RRC:   begin d.op = ALU_RRC;   d.upd_c = 1'b1; end
               SUB_SWAP:  d.op = ALU_SWAP;
               SUB_DECSZ: begin d.op = ALU_DEC; d.flow = FLOW_SKIPZ; end
               SUB_INCSZ: begin d.op = ALU_INC; d.flow = FLOW_SKIPZ; end
               SUB_MISC: begin
                  if (w[7]) begin
                     d.op = ALU_PASS_ACC;
                  end else begin
                     // no-op form and unlisted low bytes both fall to none
                     unique case (w[7:0])
                        LOW_RETURN: d.flow = FLOW_RETURN;
                        LOW_RETI:   d.flow = FLOW_RETI;
                        LOW_SLEEP:  begin d.standby = 1'b1;
                                       d.wd_clear = 1'b1; end
                        LOW_WDCLR:  d.wd_clear = 1'b1;
                        default:    d.flow = FLOW_SEQ;
                     endcase
                  end
               end
            endcase
         end
         CLASS_BIT: begin
            unique case (w[11:10])
               BSUB_CLR:   d.op = ALU_BIT_CLR;
               BSUB_SET:   d.op = ALU_BIT_SET;
               BSUB_TSTCL: begin d.op = ALU_BIT_TEST;
                              d.flow = FLOW_SKIPCLR; end
               BSUB_TSTST: begin d.op = ALU_BIT_TEST;
                              d.flow = FLOW_SKIPSET; end
            endcase
         end
         CLASS_BRANCH: begin
            d.flow = w[11] ? FLOW_JUMP : FLOW_CALL;
         end
         CLASS_LIT: begin
            d.src_lit = 1'b1;
            casez (w[11:8])
               4'b00??: d.op = ALU_LOAD_LIT;
               4'b01??: begin d.op = ALU_LOAD_LIT;
                           d.flow = FLOW_RETLIT; end
               4'b1000: begin d.op = ALU_OR;  d.upd_z = 1'b1; end
               4'b1001: begin d.op = ALU_AND; d.upd_z = 1'b1; end
               4'b1010: begin d.op = ALU_XOR; d.upd_z = 1'b1; end
               4'b110?: begin d.op = ALU_SUB; d.upd_c = 1'b1;
                           d.upd_dc = 1'b1; d.upd_z = 1'b1; end
               4'b111?: begin d.op = ALU_ADD; d.upd_c = 1'b1;
                           d.upd_dc = 1'b1; d.upd_z = 1'b1; end
               default: d.src_lit = 1'b0;
            endcase
         end
      endcase
      return d;
   endfunction

   // =========================================================
   // sequencing
   state_t              state;
   flow_t               flow;
   logic                run;
   logic                wake_req;
   logic                is_standby;
   logic                is_wd_clear;
   logic [INSN_W-1:0]   ir;
   logic [31:0]         retired;
   logic                advance;
   logic                cycle_start;
   logic                cycle_end;
   logic                skip_taken;
   logic                branching;
   logic                returning;
   decode_t             next_dec;

   // the quarter counter freezes in standby, so the oscillator stop is real
   assign advance     = run && (state != ST_STANDBY);
   assign cycle_start = advance && (q_phase == 2'h0);
   assign cycle_end   = advance && (q_phase == Q_LAST);
   assign next_dec    = decode(instr_word);
   assign fetch_strobe = cycle_start && (state == ST_EXEC);

   assign branching = (flow == FLOW_CALL) || (flow == FLOW_JUMP);
   assign returning = (flow == FLOW_RETURN) || (flow == FLOW_RETI) ||
                      (flow == FLOW_RETLIT);
   assign skip_taken = ((flow == FLOW_SKIPZ) && alu_zero) ||
                       ((flow == FLOW_SKIPCLR) && !tested_bit) ||
                       ((flow == FLOW_SKIPSET) && tested_bit);
   assign stack_push = cycle_end && exec_valid && (flow == FLOW_CALL);
   assign stack_pop  = cycle_end && exec_valid && returning;
   assign watchdog_clear = cycle_end && exec_valid && is_wd_clear;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_phase <= 2'h0;
      end else if (advance) begin
         q_phase <= q_phase + 2'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_EXEC;
      end else begin
         unique case (state)
            ST_EXEC: begin
               if (cycle_end && exec_valid && is_standby) begin
                  state <= ST_STANDBY;
               end else if (cycle_end && exec_valid &&
                            (branching || returning || skip_taken)) begin
                  state <= ST_FLUSH;
               end
            end
            ST_FLUSH: begin
               if (cycle_end) begin
                  state <= ST_EXEC;
               end
            end
            ST_STANDBY: begin
               if (wake_req) begin
                  state <= ST_EXEC;
               end
            end
            default: state <= ST_EXEC;
         endcase
      end
   end

   // decoded outputs are registered at the first quarter of each cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ir              <= '0;
         exec_valid      <= 1'b0;
         alu_op          <= ALU_NONE;
         flow            <= FLOW_SEQ;
         dest_is_reg     <= 1'b0;
         src_literal     <= 1'b0;
         upd_carry       <= 1'b0;
         upd_digit_carry <= 1'b0;
         upd_zero        <= 1'b0;
         is_standby      <= 1'b0;
         is_wd_clear     <= 1'b0;
         file_addr       <= '0;
         bit_sel         <= '0;
         literal         <= '0;
      end else if (cycle_start && state == ST_EXEC) begin
         ir              <= instr_word;
         exec_valid      <= 1'b1;
         alu_op          <= next_dec.op;
         flow            <= next_dec.flow;
         dest_is_reg     <= next_dec.dest_reg;
         src_literal     <= next_dec.src_lit;
         upd_carry       <= next_dec.upd_c;
         upd_digit_carry <= next_dec.upd_dc;
         upd_zero        <= next_dec.upd_z;
         is_standby      <= next_dec.standby;
         is_wd_clear     <= next_dec.wd_clear;
         file_addr       <= instr_word[FILE_W-1:0];
         bit_sel         <= instr_word[9:7];
         literal         <= instr_word[LIT_W-1:0];
      end else if (cycle_start) begin
         // second cycle of a two-cycle instruction does nothing
         exec_valid      <= 1'b0;
         alu_op          <= ALU_NONE;
         flow            <= FLOW_SEQ;
         upd_carry       <= 1'b0;
         upd_digit_carry <= 1'b0;
         upd_zero        <= 1'b0;
         is_standby      <= 1'b0;
         is_wd_clear     <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_counter <= '0;
      end else if (fetch_strobe) begin
         program_counter <= program_counter + PC_W'(1);
      end else if (cycle_end && exec_valid) begin
         if (branching) begin
            program_counter <= {page_bits, ir[TARGET_W-1:0]};
         end else if (returning) begin
            program_counter <= return_addr;
         end else if (skip_taken) begin
            program_counter <= program_counter + PC_W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout_flag   <= FLAG_RESET;
         powerdown_flag <= FLAG_RESET;
         osc_stop       <= 1'b0;
      end else if (cycle_end && exec_valid && is_standby) begin
         timeout_flag   <= 1'b1;
         powerdown_flag <= 1'b0;
         osc_stop       <= 1'b1;
      end else if (cycle_end && exec_valid && is_wd_clear) begin
         timeout_flag   <= 1'b1;
         powerdown_flag <= 1'b1;
      end else if (wake_req && state == ST_STANDBY) begin
         osc_stop       <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         retired <= '0;
      end else if (cycle_end && exec_valid) begin
         retired <= retired + 32'h0000_0001;
      end
   end

   // =========================================================
   // apb slave, zero wait states
   logic apb_setup;
   logic apb_write;

   assign pready    = 1'b1;
   assign apb_setup = psel && !penable;
   assign apb_write = psel && penable && pwrite;
   assign wake_req  = apb_write && (paddr == CTRL_OFS) &&
                      pwdata[CTRL_WAKE_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run <= CTRL_RUN_RESET;
      end else if (apb_write && paddr == CTRL_OFS) begin
         run <= pwdata[CTRL_RUN_BIT];
      end
   end

   // read data is captured in setup so it comes straight from flip-flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (apb_setup) begin
         prdata  <= '0;
         pslverr <= 1'b0;
         unique case (paddr)
            CTRL_OFS:   prdata[CTRL_RUN_BIT] <= run;
            STATUS_OFS: begin
               prdata[ST_TIMEOUT_BIT] <= timeout_flag;
               prdata[ST_PWRDN_BIT]   <= powerdown_flag;
               prdata[ST_STANDBY_BIT] <= (state == ST_STANDBY);
               prdata[ST_FLUSH_BIT]   <= (state == ST_FLUSH);
            end
            INSN_OFS:   prdata[INSN_W-1:0] <= ir;
            COUNT_OFS:  prdata <= retired;
            default:    pslverr <= 1'b1;
         endcase
      end
   end

   // =========================================================
   // checks
   q_wrap_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      cycle_end |=> (q_phase == 2'h0))
      else $error("quarter counter did not wrap after four periods");

   dest_sel_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (fetch_strobe && instr_word[13:12] == CLASS_BYTE)
      |=> (dest_is_reg == $past(instr_word[7])))
      else $error("destination select does not follow bit seven");

   file_field_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      fetch_strobe |=> (file_addr == $past(instr_word[6:0])))
      else $error("file address field mismatch");

   bit_field_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      fetch_strobe |=> (bit_sel == $past(instr_word[9:7])))
      else $error("bit select field mismatch");

   branch_two_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cycle_end && exec_valid && branching)
      |=> (state == ST_FLUSH) ##4 (state == ST_EXEC))
      else $error("call or jump did not take exactly two cycles");

   bit_noflag_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (fetch_strobe && instr_word[13:12] == CLASS_BIT)
      |=> !(upd_carry || upd_digit_carry || upd_zero))
      else $error("bit operation requested a flag update");

   skip_flush_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cycle_end && exec_valid && skip_taken && !is_standby)
      |=> (state == ST_FLUSH) ##1 !exec_valid)
      else $error("taken skip did not flush the next cycle");

   sleep_flags_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cycle_end && exec_valid && is_standby)
      |=> (timeout_flag && !powerdown_flag && osc_stop) [*2])
      else $error("standby did not set the power flags");

   unknown_nop_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (fetch_strobe && instr_word[13:8] == 6'h3B)
      |=> (alu_op == ALU_NONE && flow == FLOW_SEQ && !upd_zero))
      else $error("undefined literal pattern did not decode as no-op");
endmodule
`default_nettype wire

// file: hdl/insn_decoder_pkg.sv
// constants and types shared by the instruction decoder
`default_nettype none
package insn_decoder_pkg;
   // =========================================================
   // word layout
   localparam int INSN_W   = 14;
   localparam int FILE_W   = 7;
   localparam int LIT_W    = 8;
   localparam int TARGET_W = 11;
   localparam int BITSEL_W = 3;
   localparam int Q_PER_CYCLE = 4;
   localparam logic [1:0] Q_LAST = 2'(Q_PER_CYCLE - 1);
   // =========================================================
   // opcode classes and subcodes
   localparam logic [1:0] CLASS_BYTE   = 2'h0;
   localparam logic [1:0] CLASS_BIT    = 2'h1;
   localparam logic [1:0] CLASS_BRANCH = 2'h2;
   localparam logic [1:0] CLASS_LIT    = 2'h3;
   localparam logic [3:0] SUB_MISC  = 4'h0;
   localparam logic [3:0] SUB_CLEAR = 4'h1;
   localparam logic [3:0] SUB_SUB   = 4'h2;
   localparam logic [3:0] SUB_DEC   = 4'h3;
   localparam logic [3:0] SUB_OR    = 4'h4;
   localparam logic [3:0] SUB_AND   = 4'h5;
   localparam logic [3:0] SUB_XOR   = 4'h6;
   localparam logic [3:0] SUB_ADD   = 4'h7;
   localparam logic [3:0] SUB_MOVE  = 4'h8;
   localparam logic [3:0] SUB_COMPL = 4'h9;
   localparam logic [3:0] SUB_INC   = 4'hA;
   localparam logic [3:0] SUB_DECSZ = 4'hB;
   localparam logic [3:0] SUB_RRC   = 4'hC;
   localparam logic [3:0] SUB_RLC   = 4'hD;
   localparam logic [3:0] SUB_SWAP  = 4'hE;
   localparam logic [3:0] SUB_INCSZ = 4'hF;
   localparam logic [1:0] BSUB_CLR   = 2'h0;
   localparam logic [1:0] BSUB_SET   = 2'h1;
   localparam logic [1:0] BSUB_TSTCL = 2'h2;
   localparam logic [1:0] BSUB_TSTST = 2'h3;
   localparam logic [7:0] LOW_RETURN = 8'h08;
   localparam logic [7:0] LOW_RETI   = 8'h09;
   localparam logic [7:0] LOW_SLEEP  = 8'h63;
   localparam logic [7:0] LOW_WDCLR  = 8'h64;
   // =========================================================
   // register map
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] INSN_OFS   = 12'h008;
   localparam logic [11:0] COUNT_OFS  = 12'h00C;
   localparam int CTRL_RUN_BIT  = 0;
   localparam int CTRL_WAKE_BIT = 1;
   localparam logic CTRL_RUN_RESET = 1'b0;
   localparam int ST_TIMEOUT_BIT = 0;
   localparam int ST_PWRDN_BIT   = 1;
   localparam int ST_STANDBY_BIT = 2;
   localparam int ST_FLUSH_BIT   = 3;
   localparam logic FLAG_RESET = 1'b1;
   // =========================================================
   // types
   typedef enum logic [4:0] {
      ALU_NONE, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_COMPL,
      ALU_MOVE, ALU_DEC, ALU_INC, ALU_RLC, ALU_RRC, ALU_SWAP, ALU_CLEAR,
      ALU_PASS_ACC, ALU_BIT_CLR, ALU_BIT_SET, ALU_BIT_TEST, ALU_LOAD_LIT
   } alu_op_t;
   typedef enum logic [3:0] {
      FLOW_SEQ, FLOW_CALL, FLOW_JUMP, FLOW_RETURN, FLOW_RETI,
      FLOW_RETLIT, FLOW_SKIPZ, FLOW_SKIPCLR, FLOW_SKIPSET
   } flow_t;
   typedef enum logic [2:0] {
      ST_EXEC    = 3'b001,
      ST_FLUSH   = 3'b010,
      ST_STANDBY = 3'b100
   } state_t;
   typedef struct packed {
      alu_op_t op;
      flow_t   flow;
      logic    dest_reg;
      logic    src_lit;
      logic    upd_c;
      logic    upd_dc;
      logic    upd_z;
      logic    standby;
      logic    wd_clear;
   } decode_t;
endpackage
`default_nettype wire

// file: verification/midrange_instruction_decoder_test.sv
// self-checking bench for the instruction decoder
`default_nettype none
module midrange_instruction_decoder_test;
   timeunit 1ns;
   timeprecision 1ps;
   import insn_decoder_pkg::*;
   logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic          alu_zero, tested_bit, fetch_strobe, stack_push;
   logic          stack_pop, exec_valid, dest_is_reg, src_literal;
   logic          upd_carry, upd_digit_carry, upd_zero, watchdog_clear;
   logic          timeout_flag, powerdown_flag, osc_stop;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rd;
   logic [13:0]   instr_word;
   logic [12:0]   program_counter;
   logic [6:0]    file_addr;
   logic [2:0]    bit_sel;
   logic [7:0]    literal;
   logic [1:0]    q_phase;
   alu_op_t       alu_op;
   int            failures, checks, cyc, last, pushes, pops, wdclr;
   insn_decoder uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .instr_word, .fetch_strobe,
      .program_counter, .return_addr(13'h0015), .page_bits(2'h0),
      .stack_push, .stack_pop, .alu_zero, .tested_bit, .exec_valid,
      .alu_op, .dest_is_reg, .src_literal, .file_addr, .bit_sel, .literal,
      .upd_carry, .upd_digit_carry, .upd_zero, .q_phase, .watchdog_clear,
      .timeout_flag, .powerdown_flag, .osc_stop);
   prog_mem_model mem (.addr(program_counter), .word(instr_word));
   // =========================================================
   // clock, reset, watchdog
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;
   // pulses stand one cycle, so one look per cycle counts each once
   always @(negedge pclk) begin
      if (stack_push === 1'b1) pushes++;
      if (stack_pop === 1'b1) pops++;
      if (watchdog_clear === 1'b1) wdclr++;
   end
   initial begin
      #20000;
      failures++;
      conclude();
   end
   // =========================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // waits for a fetch, then judges counter, spacing and decode
   task automatic fetch(input logic [12:0] pc, input int gap,
      input logic [13:0] w, input alu_op_t op, input logic [5:0] f,
      input logic [5:0] m);
      @(negedge pclk);
      while (fetch_strobe !== 1'b1) begin
         @(negedge pclk);
      end
      chk(program_counter, pc);
      if (gap > 0) chk(cyc - last, gap);
      last = cyc;
      @(posedge pclk);
      #1;
      chk(q_phase, 2'h1);
      chk(alu_op, op);
      chk({dest_is_reg, src_literal, upd_carry, upd_digit_carry, upd_zero,
           exec_valid} & m, f & m);
      chk({file_addr, bit_sel}, {w[6:0], w[9:7]});
      if (src_literal === 1'b1) chk(literal, w[7:0]);
   endtask
   // =========================================================
   // scenarios
   task automatic reg_access();
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[1:0], 2'h3);
      apb(1'b0, 12'h010, 32'h0);
      chk(pslverr, 1'b1);
      apb(1'b1, CTRL_OFS, 32'h1);
   endtask
   task automatic run_program();
      fetch(13'h0, 0, 14'h07FF, ALU_ADD, 6'h2F, 6'h3F);
      fetch(13'h1, 4, 14'h0D05, ALU_RLC, 6'h09, 6'h3F);
      fetch(13'h2, 4, 14'h1692, ALU_BIT_SET, 6'h01, 6'h1F);
      @(posedge pclk) tested_bit <= 1'b1;
      fetch(13'h3, 4, 14'h3FA5, ALU_ADD, 6'h1F, 6'h1F);
      fetch(13'h4, 4, 14'h1C00, ALU_BIT_TEST, 6'h01, 6'h1F);
      fetch(13'h6, 8, 14'h2810, ALU_NONE, 6'h01, 6'h1F);
      fetch(13'h10, 8, 14'h3B00, ALU_NONE, 6'h01, 6'h1F);
      fetch(13'h11, 4, 14'h0B20, ALU_DEC, 6'h01, 6'h3F);
      fetch(13'h12, 4, 14'h0063, ALU_NONE, 6'h01, 6'h1F);
   endtask
   task automatic standby_check();
      repeat (4) @(posedge pclk);
      #1;
      chk({osc_stop, timeout_flag, powerdown_flag}, 3'b110);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[2:0], 3'h5);
   endtask
   // wake, watchdog clear, call, return with literal, skip on zero
   task automatic wake_and_return();
      apb(1'b1, CTRL_OFS, 32'h3);
      #1;
      chk(osc_stop, 1'b0);
      fetch(13'h13, 0, 14'h0064, ALU_NONE, 6'h01, 6'h3F);
      fetch(13'h14, 4, 14'h2018, ALU_NONE, 6'h01, 6'h1F);
      chk({timeout_flag, powerdown_flag}, 2'h3);
      chk(wdclr, 2);
      fetch(13'h18, 8, 14'h345A, ALU_LOAD_LIT, 6'h11, 6'h3F);
      chk(pushes, 1);
      fetch(13'h15, 8, 14'h0F20, ALU_INC, 6'h01, 6'h3F);
      chk(pops, 1);
      @(posedge pclk) alu_zero <= 1'b1;
      fetch(13'h17, 8, 14'h393C, ALU_AND, 6'h13, 6'h3F);
   endtask
   task automatic conclude();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; alu_zero = 1'b0;
      tested_bit = 1'b0; cyc = 0; last = 0; failures = 0; checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      reg_access();
      run_program();
      standby_check();
      wake_and_return();
      conclude();
   end
endmodule
`default_nettype wire

// file: verification/prog_mem_model.sv
// program memory model feeding instruction words to the decoder
`default_nettype none
module prog_mem_model
   import insn_decoder_pkg::*;
(
   // fetch side
   input  wire logic [12:0]       addr,
   output var  logic [INSN_W-1:0] word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [INSN_W-1:0] mem [32];
   // =========================================================
   // program image
   initial begin
      foreach (mem[i]) mem[i] = 14'h0000;
      mem[0]  = 14'h07FF;
      mem[1]  = 14'h0D05;
      mem[2]  = 14'h1692;
      mem[3]  = 14'h3FA5;
      mem[4]  = 14'h1C00;
      mem[5]  = 14'h07FF;
      mem[6]  = 14'h2810;
      mem[16] = 14'h3B00;
      mem[17] = 14'h0B20;
      mem[18] = 14'h0063;
      mem[19] = 14'h0064;
      mem[20] = 14'h2018;
      mem[21] = 14'h0F20;
      mem[23] = 14'h393C;
      mem[24] = 14'h345A;
   end
   // whole word per address, no wait states
   always_comb word = mem[addr[4:0]];
endmodule
`default_nettype wire
